// >>> logic/async_serial_pkg.sv
// Constants, types and helper functions for the asynchronous serial port
//
// Function
// - While break_send is set keep sending break characters, then one high bit.
// - Rising tx_on sends 10 or 11 idle bits before the first character.
// - Re-enabling tx_on mid-character sends a fresh preamble after the current word.
// - Toggling tx_on discards the word waiting in tx_holding.
// - Receiver hunts for start bit once rx_on is set; LSB first.
// - Ninth received bit goes to rx_ninth_bit in 9-bit mode.
// - Completed character moves to rx_holding, sets rx_full_flag, may interrupt.
// - rx_full_flag clears on status access followed by data read.
// - tx_empty_flag and tx_done_flag clear on status access then data write.
// - Idle line sets idle flag and interrupts when idle_irq_en allows.
// - Overrun sets overrun_flag, keeps rx_holding, interrupts under rx_irq_en.
// - Noise sets noise_flag with rx_full_flag, data still transferred, no own interrupt.
// - Missing stop bit or break sets frame_err_flag, data still transferred.
// - Received break reads back as framing error with data 00h.
// - Nonzero fine divider further divides that direction by 1 to 255.
// - While muted no receive flag is set and receive interrupts are suppressed.
// - Muted with idle wake method: idle line clears mute_req, idle flag stays clear.
// - Muted with address wake: word MSB one clears mute_req and is received.
// - With parity_on the word's top data bit is replaced by parity.
// - Parity over 7 or 8 low bits plus parity bit, even or odd.
// - Receive parity mismatch sets parity_err_flag and may interrupt.
// - After a data character's stop bit set tx_done_flag and may interrupt.
// - Transmit line low during start bits and high during stop bits.
package async_serial_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [2:0] ADDR_STATUS  = 3'h0;
  localparam logic [2:0] ADDR_DATA    = 3'h1;
  localparam logic [2:0] ADDR_CTRL1   = 3'h2;
  localparam logic [2:0] ADDR_CTRL2   = 3'h3;
  localparam logic [2:0] ADDR_RATE    = 3'h4;
  localparam logic [2:0] ADDR_TX_FINE = 3'h5;
  localparam logic [2:0] ADDR_RX_FINE = 3'h6;

  localparam logic [7:0] STATUS_RST = 8'hc0;

  // ****************************************
  // Frame timing
  // ****************************************
  localparam logic [3:0] OVS_LAST   = 4'hf;  // Last of 16 ticks per bit
  localparam logic [3:0] SMP_A      = 4'h7;
  localparam logic [3:0] SMP_B      = 4'h8;
  localparam logic [3:0] SMP_C      = 4'h9;
  localparam logic [3:0] LEN_WORD8  = 4'ha;  // 10 bit times
  localparam logic [3:0] LEN_WORD9  = 4'hb;  // 11 bit times
  localparam logic [7:0] IDLE_TICK8 = 8'ha0; // 10 bits of 16 ticks
  localparam logic [7:0] IDLE_TICK9 = 8'hb0; // 11 bits of 16 ticks

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic tx_empty;
    logic tx_done;
    logic rx_full;
    logic idle;
    logic overrun;
    logic noise;
    logic frame_err;
    logic parity_err;
  } status_s;

  typedef struct packed {
    logic [1:0] common;
    logic [2:0] power;
    logic [7:0] fine;
  } rate_sel_s;

  typedef enum logic [2:0] {TXK_NONE, TXK_PRE, TXK_BRK, TXK_MARK, TXK_DATA} tx_kind_e;
  typedef enum logic {RX_HUNT, RX_BITS} rx_state_e;

  // ****************************************
  // Functions
  // ****************************************
  // Clock cycles per oversampling tick
  function automatic logic [18:0] tick_div(input logic [1:0] c, input logic [2:0] p,
                                           input logic [7:0] f);
    logic [3:0]  cmul;
    logic [10:0] scaled;
    logic [7:0]  fine_eff;
    cmul     = (c == 2'h0) ? 4'h1 : (c == 2'h1) ? 4'h3 : (c == 2'h2) ? 4'h4 : 4'hd;
    scaled   = {7'h0, cmul} << p;
    fine_eff = (f == 8'h0) ? 8'h1 : f;
    return 19'(scaled * fine_eff);
  endfunction

  // Parity bit over the 7 or 8 low data bits
  function automatic logic par_bit(input logic [8:0] d, input logic nine, input logic odd);
    return (nine ? (^d[7:0]) : (^d[6:0])) ^ odd;
  endfunction

  // Majority of three samples
  function automatic logic vote(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

endpackage

// >>> logic/baud_tick.sv
// Oversampling tick generator for one direction
`timescale 1ns/1ps
module baud_tick #(
  parameter int CNT_W = 19
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_srst,
  input  wire logic                       i_run,
  input  wire async_serial_pkg::rate_sel_s i_sel,
  output logic                            o_tick
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] div_last;

  // Terminal count of the divider chain
  // conventional divider
  assign div_last = CNT_W'(async_serial_pkg::tick_div(i_sel.common, i_sel.power, i_sel.fine)
                           - 19'h1);

  // Counter restarts whenever i_run is low, and after each terminal count
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_run || cnt_r >= div_last) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // One-cycle tick at the terminal count
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_run && (cnt_r >= div_last);
    end
  end

endmodule // baud_tick

// >>> logic/async_serial_port.sv
// Full-duplex asynchronous serial port with register port
`timescale 1ns/1ps
module async_serial_port (
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_SRST,
  input  wire logic [2:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic      [7:0] O_RDATA,
  input  wire logic       I_IRQ_MASK,
  output logic            O_IRQ,
  input  wire logic       I_RX,
  output logic            O_TX,
  output logic            O_TX_OE_N
);

  // ****************************************
  // Declarations
  // ****************************************
  async_serial_pkg::status_s   st_r;
  async_serial_pkg::tx_kind_e  tx_kind_r;
  async_serial_pkg::rx_state_e rx_state_r;
  logic       tx_ninth_r, word9_r, resume_method_r, parity_on_r, parity_odd_r, par_ie_r;
  logic       txe_ie_r, done_ie_r, rx_irq_en_r, idle_irq_en_r;
  logic       tx_on_r, rx_on_r, mute_req_r, break_send_r;
  logic [7:0] rate_r, tx_fine_div_r, rx_fine_div_r;
  logic [7:0] rx_holding_r, tx_holding_r;
  logic       rx_ninth_bit_r, hold_valid_r, status_seen_r;
  logic [10:0] tx_shift_r;
  logic [3:0] tx_bit_r, tx_len_r, tx_ph_r;
  logic       pre_pend_r, after_brk_r, tx_on_d_r;
  logic [3:0] rx_ph_r, rx_idx_r;
  logic [1:0] smp_r;
  logic [8:0] rx_shift_r;
  logic       rx_noise_r, idle_arm_r;
  logic [7:0] idle_cnt_r;
  logic       tx_tick, rx_tick;
  logic       stat_rd, data_rd, data_wr, clr_rx, clr_tx;
  logic       tx_end, tx_free, tx_rise, load_pre, load_brk, load_mark, load_data, tx_load;
  logic [8:0] tx_word;
  logic [10:0] data_frame;
  logic [3:0] word_len, rx_last;
  logic       maj, smp_noise, rx_done, rx_msb, addr_wake, accept, par_bad;
  logic       idle_hit;
  logic [7:0] idle_target;

  // ****************************************
  // Register port decode
  // ****************************************
  assign stat_rd = I_RD && (I_ADDR == async_serial_pkg::ADDR_STATUS);
  assign data_rd = I_RD && (I_ADDR == async_serial_pkg::ADDR_DATA);
  assign data_wr = I_WR && (I_ADDR == async_serial_pkg::ADDR_DATA);
  assign clr_rx  = data_rd && status_seen_r;
  assign clr_tx  = data_wr && status_seen_r;
  assign word_len = word9_r ? async_serial_pkg::LEN_WORD9 : async_serial_pkg::LEN_WORD8;

  // Status access arms the clear sequence, data access consumes it
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || data_rd || data_wr) begin
      status_seen_r <= 1'b0;
    end else if (stat_rd) begin
      status_seen_r <= 1'b1;
    end
  end

  // Software control registers
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      {tx_ninth_r, word9_r, resume_method_r, parity_on_r, parity_odd_r, par_ie_r} <= 6'h00;
      {txe_ie_r, done_ie_r, rx_irq_en_r, idle_irq_en_r} <= 4'h0;
      {tx_on_r, rx_on_r, break_send_r} <= 3'h0;
      rate_r        <= 8'h00;
      tx_fine_div_r <= 8'h00;
      rx_fine_div_r <= 8'h00;
    end else if (I_WR) begin
      if (I_ADDR == async_serial_pkg::ADDR_CTRL1) begin
        {tx_ninth_r, word9_r, resume_method_r, parity_on_r, parity_odd_r, par_ie_r}
          <= {I_WDATA[6], I_WDATA[4:0]};
      end else if (I_ADDR == async_serial_pkg::ADDR_CTRL2) begin
        {txe_ie_r, done_ie_r, rx_irq_en_r, idle_irq_en_r} <= I_WDATA[7:4];
        {tx_on_r, rx_on_r, break_send_r} <= {I_WDATA[3:2], I_WDATA[0]};
      end else if (I_ADDR == async_serial_pkg::ADDR_RATE) begin
        rate_r <= I_WDATA;
      end else if (I_ADDR == async_serial_pkg::ADDR_TX_FINE) begin
        tx_fine_div_r <= I_WDATA;
      end else if (I_ADDR == async_serial_pkg::ADDR_RX_FINE) begin
        rx_fine_div_r <= I_WDATA;
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || !I_RD) begin
      O_RDATA <= 8'h00;
    end else if (I_ADDR == async_serial_pkg::ADDR_STATUS) begin
      O_RDATA <= st_r;
    end else if (I_ADDR == async_serial_pkg::ADDR_DATA) begin
      O_RDATA <= rx_holding_r;
    end else if (I_ADDR == async_serial_pkg::ADDR_CTRL1) begin
      O_RDATA <= {rx_ninth_bit_r, tx_ninth_r, 1'b0, word9_r, resume_method_r,
                  parity_on_r, parity_odd_r, par_ie_r};
    end else if (I_ADDR == async_serial_pkg::ADDR_CTRL2) begin
      O_RDATA <= {txe_ie_r, done_ie_r, rx_irq_en_r, idle_irq_en_r,
                  tx_on_r, rx_on_r, mute_req_r, break_send_r};
    end else if (I_ADDR == async_serial_pkg::ADDR_RATE) begin
      O_RDATA <= rate_r;
    end else if (I_ADDR == async_serial_pkg::ADDR_TX_FINE) begin
      O_RDATA <= tx_fine_div_r;
    end else if (I_ADDR == async_serial_pkg::ADDR_RX_FINE) begin
      O_RDATA <= rx_fine_div_r;
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  // ****************************************
  // Rate generators
  // ****************************************
  baud_tick #(.CNT_W(19)) u_tx_tick (
    .i_clk  (I_CLK_SYS),
    .i_srst (I_SRST),
    .i_run  (tx_on_r || (tx_kind_r != async_serial_pkg::TXK_NONE)),
    .i_sel  ({rate_r[7:6], rate_r[5:3], tx_fine_div_r}),
    .o_tick (tx_tick)
  );

  baud_tick #(.CNT_W(19)) u_rx_tick (
    .i_clk  (I_CLK_SYS),
    .i_srst (I_SRST),
    .i_run  (rx_on_r),
    .i_sel  ({rate_r[7:6], rate_r[2:0], rx_fine_div_r}),
    .o_tick (rx_tick)
  );

  // ****************************************
  // Transmitter
  // ****************************************
  assign tx_end  = (tx_kind_r != async_serial_pkg::TXK_NONE) && tx_tick
                   && (tx_ph_r == async_serial_pkg::OVS_LAST) && (tx_bit_r == tx_len_r - 4'h1);
  assign tx_free = (tx_kind_r == async_serial_pkg::TXK_NONE) || tx_end;
  assign tx_rise = tx_on_r && !tx_on_d_r;
  assign load_pre  = tx_free && tx_on_r && (pre_pend_r || tx_rise);
  assign load_brk  = tx_free && !load_pre && tx_on_r && break_send_r;
  assign load_mark = tx_free && !load_pre && !load_brk && after_brk_r;
  assign load_data = tx_free && !load_pre && !load_brk && !load_mark && tx_on_r && hold_valid_r;
  assign tx_load   = load_pre || load_brk || load_mark || load_data;

  always_comb begin
    tx_word = {word9_r & tx_ninth_r, tx_holding_r};
    if (parity_on_r && word9_r) begin
      tx_word[8] = async_serial_pkg::par_bit(tx_word, 1'b1, parity_odd_r);
    end else if (parity_on_r) begin
      tx_word[7] = async_serial_pkg::par_bit(tx_word, 1'b0, parity_odd_r);
    end
  end
  // start bit low, stop bit high
  assign data_frame = word9_r ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};

  // Shifter, bit and tick counters; line is the shifter's low bit
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      tx_kind_r  <= async_serial_pkg::TXK_NONE;
      tx_shift_r <= 11'h7ff;
      tx_bit_r   <= 4'h0;
      tx_len_r   <= 4'h1;
      tx_ph_r    <= 4'h0;
    end else if (tx_load) begin
      tx_bit_r <= 4'h0;
      tx_ph_r  <= 4'h0;
      tx_len_r <= load_mark ? 4'h1 : word_len;
      if (load_pre) begin
        tx_kind_r  <= async_serial_pkg::TXK_PRE;
        tx_shift_r <= 11'h7ff;
      end else if (load_brk) begin
        tx_kind_r  <= async_serial_pkg::TXK_BRK;
        tx_shift_r <= word9_r ? 11'h000 : 11'h400;
      end else if (load_mark) begin
        tx_kind_r  <= async_serial_pkg::TXK_MARK;
        tx_shift_r <= 11'h7ff;
      end else begin
        tx_kind_r  <= async_serial_pkg::TXK_DATA;
        tx_shift_r <= data_frame;
      end
    end else if (tx_end) begin
      tx_kind_r  <= async_serial_pkg::TXK_NONE;
      tx_shift_r <= 11'h7ff;
    end else if (tx_tick && tx_kind_r != async_serial_pkg::TXK_NONE) begin
      tx_ph_r <= tx_ph_r + 4'h1;
      if (tx_ph_r == async_serial_pkg::OVS_LAST) begin
        tx_bit_r   <= tx_bit_r + 4'h1;
        tx_shift_r <= {1'b1, tx_shift_r[10:1]};
      end
    end
  end

  // Enable edge, pending preamble, break tail and holding word
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      tx_on_d_r    <= 1'b0;
      pre_pend_r   <= 1'b0;
      after_brk_r  <= 1'b0;
      hold_valid_r <= 1'b0;
      tx_holding_r <= 8'h00;
      O_TX_OE_N    <= 1'b1;
    end else begin
      tx_on_d_r <= tx_on_r;
      O_TX_OE_N <= !(tx_on_r || (tx_kind_r != async_serial_pkg::TXK_NONE));
      if (load_pre || !tx_on_r) begin
        pre_pend_r <= 1'b0;
      end else if (tx_rise) begin
        pre_pend_r <= 1'b1;
      end
      if (load_brk) begin
        after_brk_r <= 1'b1;
      end else if (tx_load) begin
        after_brk_r <= 1'b0;
      end
      // enable toggle drops the waiting word
      if (data_wr) begin
        hold_valid_r <= 1'b1;
        tx_holding_r <= I_WDATA;
      end else if (load_data || tx_rise) begin
        hold_valid_r <= 1'b0;
      end
    end
  end
  assign O_TX = tx_shift_r[0];

  // ****************************************
  // Receiver
  // ****************************************
  assign rx_last   = word9_r ? 4'ha : 4'h9;
  assign maj       = async_serial_pkg::vote(smp_r[0], smp_r[1], I_RX);
  assign smp_noise = !((smp_r[0] == smp_r[1]) && (smp_r[1] == I_RX));
  assign rx_done   = (rx_state_r == async_serial_pkg::RX_BITS) && rx_tick
                     && (rx_ph_r == async_serial_pkg::SMP_C) && (rx_idx_r == rx_last);
  assign rx_msb    = word9_r ? rx_shift_r[8] : rx_shift_r[7];
  assign addr_wake = rx_done && mute_req_r && resume_method_r && rx_msb;
  assign accept    = rx_done && (!mute_req_r || addr_wake);
  assign par_bad   = parity_on_r
                     && (rx_msb != async_serial_pkg::par_bit(rx_shift_r, word9_r, parity_odd_r));
  assign idle_target = word9_r ? async_serial_pkg::IDLE_TICK9 : async_serial_pkg::IDLE_TICK8;
  assign idle_hit  = rx_on_r && (rx_state_r == async_serial_pkg::RX_HUNT) && rx_tick && I_RX
                     && (idle_cnt_r == idle_target - 8'h1);

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || !rx_on_r) begin
      rx_state_r <= async_serial_pkg::RX_HUNT;
      rx_ph_r    <= 4'h0;
      rx_idx_r   <= 4'h0;
      smp_r      <= 2'h3;
      rx_shift_r <= 9'h000;
      rx_noise_r <= 1'b0;
    end else if (rx_tick && rx_state_r == async_serial_pkg::RX_HUNT) begin
      if (!I_RX) begin
        rx_state_r <= async_serial_pkg::RX_BITS;
        rx_ph_r    <= 4'h1;
        rx_idx_r   <= 4'h0;
        rx_noise_r <= 1'b0;
        rx_shift_r <= 9'h000;
      end
    end else if (rx_tick) begin
      rx_ph_r <= rx_ph_r + 4'h1;
      if (rx_ph_r == async_serial_pkg::SMP_A) begin
        smp_r[0] <= I_RX;
      end else if (rx_ph_r == async_serial_pkg::SMP_B) begin
        smp_r[1] <= I_RX;
      end else if (rx_ph_r == async_serial_pkg::SMP_C) begin
        rx_noise_r <= rx_noise_r | smp_noise;
        if ((rx_idx_r == 4'h0 && maj) || rx_idx_r == rx_last) begin
          rx_state_r <= async_serial_pkg::RX_HUNT;
        end else if (rx_idx_r != 4'h0) begin
          rx_shift_r[rx_idx_r - 4'h1] <= maj;
        end
      end else if (rx_ph_r == async_serial_pkg::OVS_LAST) begin
        rx_idx_r <= rx_idx_r + 4'h1;
      end
    end
  end

  // Run of high ticks while hunting
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST || rx_state_r != async_serial_pkg::RX_HUNT || (rx_tick && !I_RX)) begin
      idle_cnt_r <= 8'h00;
    end else if (rx_tick && idle_cnt_r != idle_target) begin
      idle_cnt_r <= idle_cnt_r + 8'h1;
    end
  end

  // ****************************************
  // Status flags and receive holding
  // ****************************************
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      st_r           <= async_serial_pkg::STATUS_RST;
      rx_holding_r   <= 8'h00;
      rx_ninth_bit_r <= 1'b0;
      mute_req_r     <= 1'b0;
      idle_arm_r     <= 1'b0;
    end else begin
      if (clr_tx) begin
        st_r.tx_empty <= 1'b0;
        st_r.tx_done  <= 1'b0;
      end
      if (clr_rx) begin
        {st_r.rx_full, st_r.idle, st_r.overrun} <= 3'h0;
        {st_r.noise, st_r.frame_err, st_r.parity_err} <= 3'h0;
      end
      // Hardware set wins over the clear sequence
      if (load_data || tx_rise) begin
        st_r.tx_empty <= 1'b1;
      end
      if (tx_end && tx_kind_r == async_serial_pkg::TXK_DATA) begin
        st_r.tx_done <= 1'b1;
      end
      if (I_WR && I_ADDR == async_serial_pkg::ADDR_CTRL2) begin
        mute_req_r <= I_WDATA[1];
      end else if (addr_wake || (idle_hit && mute_req_r && !resume_method_r)) begin
        mute_req_r <= 1'b0;
      end
      if (accept) begin
        idle_arm_r <= 1'b1;
        if (st_r.rx_full) begin
          st_r.overrun <= 1'b1;
        end else begin
          rx_holding_r   <= rx_shift_r[7:0];
          rx_ninth_bit_r <= word9_r & rx_shift_r[8];
          st_r.rx_full   <= 1'b1;
          st_r.noise     <= rx_noise_r | smp_noise;
          st_r.frame_err <= !maj;
          st_r.parity_err <= par_bad;
        end
      end
      if (idle_hit && !mute_req_r && idle_arm_r) begin
        st_r.idle  <= 1'b1;
        idle_arm_r <= 1'b0;
      end
    end
  end

  // Interrupt request, receive sources suppressed while muted
  // muted receive interrupts off
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= !I_IRQ_MASK && ((st_r.tx_empty && txe_ie_r) || (st_r.tx_done && done_ie_r)
               || (!mute_req_r && (((st_r.rx_full || st_r.overrun) && rx_irq_en_r)
               || (st_r.idle && idle_irq_en_r) || (st_r.parity_err && par_ie_r))));
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_start_low: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    tx_kind_r == async_serial_pkg::TXK_DATA && tx_bit_r == 4'h0 |-> !O_TX)
    else $error("start bit not low");
  a_stop_high: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    tx_kind_r == async_serial_pkg::TXK_DATA && tx_bit_r == tx_len_r - 4'h1 |-> O_TX)
    else $error("stop bit not high");
  a_break_low: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    tx_kind_r == async_serial_pkg::TXK_BRK && tx_bit_r < 4'ha |-> !O_TX)
    else $error("break bit not low");
  a_pre_len: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    load_pre |=> tx_len_r == ($past(word9_r) ? 4'hb : 4'ha) && O_TX)
    else $error("preamble length wrong");
  a_done_set: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    tx_end && tx_kind_r == async_serial_pkg::TXK_DATA |=> st_r.tx_done)
    else $error("done flag missing");
  a_ovr_keep: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    accept && st_r.rx_full |=> st_r.overrun && $stable(rx_holding_r))
    else $error("overrun handling wrong");
  a_rx_clear: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    stat_rd ##1 (data_rd && !accept) |=> !st_r.rx_full)
    else $error("full flag not cleared");
  a_mute_quiet: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    rx_done && mute_req_r && !addr_wake && !clr_rx |=> $stable(st_r[5:0]))
    else $error("muted receiver set a flag");
  a_idle_wake: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    idle_hit && mute_req_r && !resume_method_r && !I_WR |=> !mute_req_r && !$rose(st_r.idle))
    else $error("idle wake wrong");
  a_rd_latency: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    stat_rd |=> O_RDATA == $past(st_r))
    else $error("status read data wrong");

endmodule // async_serial_port

// >>> dv/serial_node.sv
// Far serial node model that drives and watches the line
`timescale 1ns/1ps
module serial_node #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_line
);
  int   bit_clks = BIT_CLKS; // Bench may slow the link
  initial o_line = 1'b1;
  task automatic send(input logic [7:0] d, input logic stp);
    for (int i = 0; i < 10; i++) begin
      o_line <= (i == 0) ? 1'b0 : (i == 9) ? stp : d[i-1];
      repeat (bit_clks) @(posedge i_clk);
    end
    o_line <= 1'b1; // Pulled high when idle
  endtask
  task automatic take(output logic [7:0] d);
    while (i_line !== 1'b0) @(posedge i_clk);
    repeat (bit_clks + bit_clks / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      d[i] = i_line;
      repeat (bit_clks) @(posedge i_clk);
    end
  endtask
endmodule // serial_node

// >>> dv/async_serial_port_bench.sv
// Self-checking bench for the asynchronous serial port
`timescale 1ns/1ps
module async_serial_port_bench;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       irq;
  logic       msk = 1'b0;
  logic       oen;
  logic       rxl;
  logic       txl;
  logic [7:0] v, b, c;
  int         err_total = 0;
  int         total_checks = 0;
  int         cyc = 0;
  always #2 clk = ~clk;
  async_serial_port DUT (.I_CLK_SYS(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_IRQ_MASK(msk), .O_IRQ(irq),
    .I_RX(rxl), .O_TX(txl), .O_TX_OE_N(oen));
  serial_node #(.BIT_CLKS(16)) peer (.i_clk(clk), .i_line(txl), .o_line(rxl));
  // Compare and count
  task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Bus write, one strobe cycle
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Bus read, data in the following cycle
  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  // Expected line byte with parity in bit 7
  function automatic logic [7:0] par_exp(input logic [7:0] d, input logic odd);
    return {(^d[6:0]) ^ odd, d[6:0]};
  endfunction
  task automatic stop_test();
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'h66d53c67));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rreg(3'h0, v);
    check("status", v, 8'hc0);
    check("oen rst", {7'h0, oen}, 8'h01);
    rreg(3'h7, v);
    check("unmapped", v, 8'h00);
    // rates set before either direction is on
    wreg(3'h4, 8'h00);
    wreg(3'h5, 8'h00);
    wreg(3'h6, 8'h00);
    wreg(3'h3, 8'h2c); // Rx irq, tx and rx on
    // Plain frames, then even and odd parity
    for (int n = 0; n < 4; n++) begin
      b = 8'($urandom);
      if (n > 1) wreg(3'h2, {5'h0, 1'b1, n == 3, 1'b0});
      rreg(3'h0, v);
      wreg(3'h1, b);
      rreg(3'h0, v);
      check("tx done clr", {7'h0, v[6]}, 8'h00);
      peer.take(c);
      if (n > 1) b = par_exp(b, n == 3);
      check("tx byte", c, b);
      repeat (12) @(posedge clk);
      rreg(3'h0, v);
      check("tx done", {7'h0, v[6]}, 8'h01);
    end
    wreg(3'h2, 8'h00);
    // Received frames, the last one a break
    for (int n = 0; n < 4; n++) begin
      b = (n == 3) ? 8'h00 : 8'($urandom);
      peer.send(b, n != 3);
      repeat (8) @(posedge clk);
      check("irq", {7'h0, irq}, 8'h01);
      rreg(3'h0, v);
      check("rx full", {7'h0, v[5]}, 8'h01);
      check("frame err", {7'h0, v[1]}, {7'h0, n == 3});
      rreg(3'h1, v);
      check("rx data", v, b);
      rreg(3'h0, v);
      check("rx flags", {2'h0, v[5:0]}, 8'h00);
    end
    b = 8'($urandom);
    peer.send(b, 1'b1);
    peer.send(~b, 1'b1);
    repeat (8) @(posedge clk);
    msk <= 1'b1;
    repeat (2) @(posedge clk);
    check("masked irq", {7'h0, irq}, 8'h00);
    msk <= 1'b0;
    rreg(3'h0, v);
    check("overrun", {7'h0, v[3]}, 8'h01);
    rreg(3'h1, v);
    check("kept data", v, b);
    // Idle line after the last character
    repeat (200) @(posedge clk);
    rreg(3'h0, v);
    check("idle", {7'h0, v[4]}, 8'h01);
    rreg(3'h1, v);
    // Break characters, then the closing high bit
    wreg(3'h3, 8'h2d);
    peer.take(c);
    check("break", c, 8'h00);
    check("oen on", {7'h0, oen}, 8'h00);
    wreg(3'h3, 8'h2c);
    repeat (200) @(posedge clk);
    check("break tail", {7'h0, txl}, 8'h01);
    // Muted receiver, idle line wake
    wreg(3'h3, 8'h2e);
    peer.send(b, 1'b1);
    repeat (8) @(posedge clk);
    rreg(3'h0, v);
    check("muted full", {7'h0, v[5]}, 8'h00);
    check("muted irq", {7'h0, irq}, 8'h00);
    repeat (180) @(posedge clk);
    rreg(3'h3, v);
    check("idle wake", {7'h0, v[1]}, 8'h00);
    rreg(3'h0, v);
    check("wake idle flag", {7'h0, v[4]}, 8'h00);
    // Muted receiver, address mark wake
    wreg(3'h2, 8'h08);
    wreg(3'h3, 8'h2e);
    peer.send({1'b0, b[6:0]}, 1'b1);
    repeat (8) @(posedge clk);
    rreg(3'h3, v);
    check("still muted", {7'h0, v[1]}, 8'h01);
    peer.send({1'b1, b[6:0]}, 1'b1);
    repeat (8) @(posedge clk);
    rreg(3'h0, v);
    check("wake full", {7'h0, v[5]}, 8'h01);
    rreg(3'h1, v);
    check("wake data", v, {1'b1, b[6:0]});
    rreg(3'h3, v);
    check("awake", {7'h0, v[1]}, 8'h00);
    // Slower rates, changed only while both directions are off
    wreg(3'h3, 8'h00);
    // rates move only while both directions are off
    wreg(3'h4, 8'h41);
    wreg(3'h5, 8'h02);
    check("oen off", {7'h0, oen}, 8'h01);
    wreg(3'h3, 8'h2c);
    peer.bit_clks = 96;
    b = 8'($urandom);
    rreg(3'h0, v);
    wreg(3'h1, b);
    peer.take(c);
    check("slow tx", c, b);
    peer.send(~b, 1'b1);
    repeat (8) @(posedge clk);
    rreg(3'h1, v);
    check("slow rx", v, ~b);
    stop_test();
  end
endmodule // async_serial_port_bench
